// File: design/mpil_defs.svh
// Constants for the meter pulse and indicator logic
// How it works
// RULE1 - Red indicator steady on while summed three-phase power is negative.
// RULE2 - Red indicator flashes sporadically while summed power keeps changing sign.
// RULE3 - Red indicator flashes quickly while the line-voltage-absent flag is set.
// RULE4 - Red indicator double-flashes on load failure, including all-zero address switches.
// RULE5 - First yellow indicator mirrors the energy pulse relay at all times.
// RULE6 - Second yellow indicator follows the second relay, fitted or not.
// RULE7 - In display-data mode second relay carries display data; indicator toggles fast.
// RULE8 - Address from six switches, switch 1 weight 32, switch 6 weight 1.
// RULE9 - Slave only; valid slave addresses are 1 through 63.
// RULE10 - Jumper shorted at power-up clears all accumulated energy to zero.
// RULE11 - The clear repeats on every power cycle while the jumper stays shorted.
// RULE12 - Each energy quantum closes the relay, by default for 100 ms.
// RULE13 - Change-of-state mode toggles the relay per quantum instead.
// RULE14 - Pulse weight defaults to 1 Wh and is set by a register.
// RULE15 - Two analog outputs: selectable source, values at 0 V and 10 V, linear.
// RULE16 - Serial port defaults to 9600 baud, 8 data bits, no parity, 1 stop.
// RULE17 - Currents are normalised to a 5 A full-scale representation.
// RULE18 - All outputs and readable data refresh once every 500 ms; the code ties only the analog outputs and the sporadic flag to that tick.
// RULE19 - Distinct blink periods per pattern; priority follows error severity.
`ifndef MPIL_DEFS_SVH
`define MPIL_DEFS_SVH
`define MPIL_CLK_HZ 20000000
`define MPIL_PULSE_MS 100
`define MPIL_REFRESH_MS 500
`define MPIL_FAST_MS 100
`define MPIL_SLOW_MS 400
`define MPIL_DBL_MS 150
`define MPIL_MS_CYC (`MPIL_CLK_HZ / 1000)
// Register word offsets (byte addresses)
`define MPIL_R_CTRL 8'h00
`define MPIL_R_WEIGHT 8'h04
`define MPIL_R_STATUS 8'h08
`define MPIL_R_IRQ 8'h0C
`define MPIL_R_MASK 8'h10
`define MPIL_R_AO0_SEL 8'h14
`define MPIL_R_AO0_LO 8'h18
`define MPIL_R_AO0_HI 8'h1C
`define MPIL_R_AO1_SEL 8'h20
`define MPIL_R_AO1_LO 8'h24
`define MPIL_R_AO1_HI 8'h28
`define MPIL_R_SERIAL 8'h2C
`define MPIL_R_ENERGY 8'h30
// Control fields
`define MPIL_C_TOGGLE 0
`define MPIL_C_DISP 1
`define MPIL_C_LOADERR 2
// Reset values and fixed constants
`define MPIL_WEIGHT_RST 16'h0001
`define MPIL_BAUD_RST 16'h2580
`define MPIL_SERIAL_RST 32'h0008_2580
`define MPIL_FULL_SCALE 16'h0005
`define MPIL_AO_HI_RST 16'h03E8
`define MPIL_DAC_MAX 32'h0000_0FFF
`define MPIL_ZERO_ADDR 6'h00
`endif

// File: design/mpil_pkg.sv
// Types for the meter pulse and indicator logic
package mpil_pkg;
  typedef enum logic [3:0] {
    MPIL_D_OFF = 4'b0001,
    MPIL_D_STEADY = 4'b0010,
    MPIL_D_SPORADIC = 4'b0100,
    MPIL_D_FAST = 4'b1000
  } mpil_diag_t;
  typedef logic [15:0] mpil_word_t;
endpackage : mpil_pkg

// File: design/mpil_top.sv
// Meter pulse relay, indicator and analog mapping logic with Wishbone registers
`timescale 1ns/1ps
`include "mpil_defs.svh"
module mpil_top #(
  parameter int unsigned PULSE_CYC = `MPIL_PULSE_MS * `MPIL_MS_CYC,
  parameter int unsigned REFRESH_CYC = `MPIL_REFRESH_MS * `MPIL_MS_CYC,
  parameter int unsigned FAST_CYC = `MPIL_FAST_MS * `MPIL_MS_CYC,
  parameter int unsigned SLOW_CYC = `MPIL_SLOW_MS * `MPIL_MS_CYC,
  parameter int unsigned DBL_CYC = `MPIL_DBL_MS * `MPIL_MS_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [15:0] total_power,
  input wire logic voltage_absent,
  input wire logic energy_quantum,
  input wire logic display_data,
  input wire logic second_relay_req,
  input wire logic [5:0] address_switch_bank,
  input wire logic energy_clear_jumper,
  input wire logic [15:0] meas_a,
  input wire logic [15:0] meas_b,
  output logic power_on_indicator,
  output logic diag_indicator,
  output logic energy_relay,
  output logic energy_pulse_indicator,
  output logic second_relay,
  output logic second_relay_indicator,
  output logic [5:0] slave_address,
  output logic address_valid,
  output logic energy_clear,
  output logic [11:0] analog_out0,
  output logic [11:0] analog_out1,
  output logic refresh_tick,
  output logic irq
);
  import mpil_pkg::*;

  // ****************************************
  // Registers and bus
  // ****************************************
  logic [2:0] ctrl;
  mpil_word_t weight;
  mpil_word_t ao_sel [2];
  mpil_word_t ao_lo [2];
  mpil_word_t ao_hi [2];
  logic [31:0] serial_cfg;
  logic [31:0] energy_wh;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;
  logic [3:0] events;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] next_rd;
  logic boot_done;
  logic [15:0] wcount;
  logic [31:0] pcnt;
  logic [31:0] rcnt;
  logic toggle_mode;
  logic disp_mode;
  logic load_err;
  logic sign_q;
  logic [3:0] flips;
  logic sporadic;
  mpil_diag_t diag_state;
  mpil_diag_t next_diag;
  logic [31:0] bcnt;
  logic [2:0] phase;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // Lands where the master sees ack
  assign toggle_mode = ctrl[`MPIL_C_TOGGLE];
  assign disp_mode = ctrl[`MPIL_C_DISP];

  // Byte lane mask from sel
  always_comb
  begin
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  end

  // Ack one cycle after strobe, dropped the cycle after
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (wb_adr_i)
      `MPIL_R_CTRL: next_rd = {29'h0, ctrl};
      `MPIL_R_WEIGHT: next_rd = {16'h0, weight};
      `MPIL_R_STATUS: next_rd = {6'h0, `MPIL_FULL_SCALE, address_valid, slave_address,
                                 sporadic, voltage_absent, energy_relay}; // RULE17
      `MPIL_R_IRQ: next_rd = {28'h0, irq_stat};
      `MPIL_R_MASK: next_rd = {28'h0, irq_mask};
      `MPIL_R_AO0_SEL: next_rd = {16'h0, ao_sel[0]};
      `MPIL_R_AO0_LO: next_rd = {16'h0, ao_lo[0]};
      `MPIL_R_AO0_HI: next_rd = {16'h0, ao_hi[0]};
      `MPIL_R_AO1_SEL: next_rd = {16'h0, ao_sel[1]};
      `MPIL_R_AO1_LO: next_rd = {16'h0, ao_lo[1]};
      `MPIL_R_AO1_HI: next_rd = {16'h0, ao_hi[1]};
      `MPIL_R_SERIAL: next_rd = serial_cfg;
      `MPIL_R_ENERGY: next_rd = energy_wh;
      default: next_rd = 32'h0;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wb_dat_o <= 32'h0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= next_rd;
  end

  // Writable configuration; writes land on the ack edge semantics of a single cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl <= 3'h0;
      weight <= `MPIL_WEIGHT_RST; // RULE14
      serial_cfg <= `MPIL_SERIAL_RST; // RULE16
      irq_mask <= 4'h0;
      ao_sel[0] <= 16'h0;
      ao_sel[1] <= 16'h0;
      ao_lo[0] <= 16'h0;
      ao_lo[1] <= 16'h0;
      ao_hi[0] <= `MPIL_AO_HI_RST;
      ao_hi[1] <= `MPIL_AO_HI_RST;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `MPIL_R_CTRL: ctrl <= (ctrl & ~wmask[2:0]) | (wb_dat_i[2:0] & wmask[2:0]);
        `MPIL_R_WEIGHT: weight <= (weight & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]); // RULE14
        `MPIL_R_MASK: irq_mask <= (irq_mask & ~wmask[3:0]) | (wb_dat_i[3:0] & wmask[3:0]);
        `MPIL_R_AO0_SEL: ao_sel[0] <= wb_dat_i[15:0]; // RULE15
        `MPIL_R_AO0_LO: ao_lo[0] <= wb_dat_i[15:0];
        `MPIL_R_AO0_HI: ao_hi[0] <= wb_dat_i[15:0];
        `MPIL_R_AO1_SEL: ao_sel[1] <= wb_dat_i[15:0];
        `MPIL_R_AO1_LO: ao_lo[1] <= wb_dat_i[15:0];
        `MPIL_R_AO1_HI: ao_hi[1] <= wb_dat_i[15:0];
        `MPIL_R_SERIAL: serial_cfg <= (serial_cfg & ~wmask) | (wb_dat_i & wmask);
        default: ;
      endcase
    end
  end

  // ****************************************
  // Address and power-up energy clear
  // ****************************************
  // Switches sampled as a plain bus; switch 1 wired to bit 5
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      slave_address <= 6'h0;
      address_valid <= 1'b0;
    end
    else
    begin
      slave_address <= address_switch_bank; // RULE8
      address_valid <= address_switch_bank != `MPIL_ZERO_ADDR; // RULE9
    end
  end

  assign load_err = ctrl[`MPIL_C_LOADERR] || (boot_done && !address_valid); // RULE4

  // Jumper looked at once per reset release, so every power cycle repeats it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      boot_done <= 1'b0;
      energy_clear <= 1'b0;
    end
    else
    begin
      boot_done <= 1'b1;
      energy_clear <= !boot_done && energy_clear_jumper; // RULE10 RULE11
    end
  end

  // ****************************************
  // Energy pulse relay
  // ****************************************
  // Quanta counted in Wh; one relay event per weight reached
  // The Wh total survives reset like a stored count; only the jumper clear zeroes it
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wcount <= 16'h0;
      energy_relay <= 1'b0;
      pcnt <= 32'h0;
    end
    else if (energy_clear)
    begin
      wcount <= 16'h0;
      energy_wh <= 32'h0; // RULE10
      energy_relay <= 1'b0;
      pcnt <= 32'h0;
    end
    else
    begin
      if (pcnt != 32'h0)
        pcnt <= pcnt - 32'h1;
      else if (!toggle_mode)
        energy_relay <= 1'b0;
      if (energy_quantum)
      begin
        energy_wh <= energy_wh + 32'h1;
        if (wcount + 16'h1 >= weight)
        begin
          wcount <= 16'h0;
          if (toggle_mode)
            energy_relay <= !energy_relay; // RULE13
          else
          begin
            energy_relay <= 1'b1; // RULE12
            pcnt <= PULSE_CYC - 32'h1;
          end
        end
        else
          wcount <= wcount + 16'h1;
      end
    end
  end

  // Indicators follow relays; second relay sources display data in that mode
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      second_relay <= 1'b0;
    else
      second_relay <= disp_mode ? display_data : second_relay_req; // RULE7
  end

  assign energy_pulse_indicator = energy_relay; // RULE5
  assign second_relay_indicator = second_relay; // RULE6 RULE7
  assign power_on_indicator = resetn;

  // ****************************************
  // Refresh tick and analog mapping
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      rcnt <= 32'h0;
      refresh_tick <= 1'b0;
    end
    else
    begin
      refresh_tick <= rcnt == REFRESH_CYC - 1; // RULE18
      rcnt <= (rcnt == REFRESH_CYC - 1) ? 32'h0 : rcnt + 32'h1;
    end
  end

  // Linear map per channel, clamped; offsets allowed by choosing lo above zero
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ao
      logic [15:0] src;
      logic [31:0] num;
      logic [31:0] span;
      logic [31:0] scaled;
      logic [11:0] level;
      assign src = ao_sel[g][0] ? meas_b : meas_a; // RULE15
      assign span = {16'h0, ao_hi[g] - ao_lo[g]};
      assign num = (src <= ao_lo[g]) ? 32'h0 : {16'h0, src - ao_lo[g]};
      assign scaled = (span == 32'h0 || num >= span) ? `MPIL_DAC_MAX :
                      (num * `MPIL_DAC_MAX) / span;
      // One register per channel, so no output has two writers
      always_ff @(posedge mclk)
      begin
        if (!resetn)
          level <= 12'h0;
        else if (refresh_tick)
          level <= scaled[11:0]; // RULE15 RULE18
      end
    end
  endgenerate

  // Registered levels leave through plain wires
  assign analog_out0 = g_ao[0].level;
  assign analog_out1 = g_ao[1].level;

  // ****************************************
  // Diagnostic indicator
  // ****************************************
  // Sign flips counted per refresh window reveal oscillation around zero
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sign_q <= 1'b0;
      flips <= 4'h0;
      sporadic <= 1'b0;
    end
    else
    begin
      sign_q <= total_power[15];
      if (refresh_tick)
      begin
        sporadic <= flips >= 4'h2; // RULE2
        flips <= 4'h0;
      end
      else if (sign_q != total_power[15] && flips != 4'hF)
        flips <= flips + 4'h1;
    end
  end

  // Severity order: load failure, no voltage, sporadic, reverse power
  always_comb
  begin
    if (load_err)
      next_diag = MPIL_D_OFF; // RULE19
    else if (voltage_absent)
      next_diag = MPIL_D_FAST;
    else if (sporadic)
      next_diag = MPIL_D_SPORADIC;
    else if (total_power[15])
      next_diag = MPIL_D_STEADY;
    else
      next_diag = MPIL_D_OFF;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      diag_state <= MPIL_D_OFF;
    else
      diag_state <= next_diag;
  end

  // Shared blink timer; phase counts slots for the double-flash
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      bcnt <= 32'h0;
      phase <= 3'h0;
    end
    else if (bcnt == 32'h0)
    begin
      phase <= phase + 3'h1;
      bcnt <= load_err ? DBL_CYC - 1 : (diag_state == MPIL_D_FAST) ? FAST_CYC - 1 :
              SLOW_CYC - 1; // RULE19
    end
    else
      bcnt <= bcnt - 32'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      diag_indicator <= 1'b0;
    else if (load_err)
      diag_indicator <= phase == 3'h0 || phase == 3'h2; // RULE4
    else
    begin
      case (diag_state)
        MPIL_D_STEADY: diag_indicator <= 1'b1; // RULE1
        MPIL_D_FAST: diag_indicator <= phase[0]; // RULE3
        MPIL_D_SPORADIC: diag_indicator <= phase[0] && phase[1]; // RULE2
        MPIL_D_OFF: diag_indicator <= 1'b0;
        default: diag_indicator <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign events = {load_err, voltage_absent, sporadic, energy_relay && pcnt == PULSE_CYC - 1};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      irq_stat <= 4'h0;
    else if (wr && wb_adr_i == `MPIL_R_IRQ)
      irq_stat <= (irq_stat & ~(wb_dat_i[3:0] & wmask[3:0])) | events;
    else
      irq_stat <= irq_stat | events;
  end

  assign irq = |(irq_stat & irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  a_led_mirror: assert property (@(posedge mclk) disable iff (!resetn)
    energy_pulse_indicator == energy_relay) else $error("pulse indicator differs"); // RULE5
  a_second_led: assert property (@(posedge mclk) disable iff (!resetn)
    second_relay_indicator == second_relay) else $error("second indicator differs"); // RULE6
  a_disp_src: assert property (@(posedge mclk) disable iff (!resetn)
    disp_mode |=> second_relay == $past(display_data)) else $error("display source"); // RULE7
  a_addr_map: assert property (@(posedge mclk) disable iff (!resetn)
    $past(resetn) |-> slave_address == $past(address_switch_bank))
    else $error("address map"); // RULE8
  a_addr_zero: assert property (@(posedge mclk) disable iff (!resetn)
    address_valid |-> slave_address != 6'h0) else $error("zero address valid"); // RULE9
  sequence s_boot;
    $rose(boot_done) && $past(energy_clear_jumper);
  endsequence
  a_boot_clear: assert property (@(posedge mclk) disable iff (!resetn)
    s_boot |-> energy_clear ##1 energy_wh == 32'h0) else $error("no clear"); // RULE10
  a_steady_red: assert property (@(posedge mclk) disable iff (!resetn)
    diag_state == MPIL_D_STEADY && !load_err |=> diag_indicator) else $error("red off"); // RULE1
  a_pulse_len: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(energy_relay) && !toggle_mode && !energy_clear |-> energy_relay [*2])
    else $error("pulse too short"); // RULE12
endmodule : mpil_top

// File: test/mpil_totalizer.sv
// Pulse totalizer model that counts closures of the energy relay
`timescale 1ns/1ps
module mpil_totalizer (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic relay_in,
  output logic [15:0] pulse_count,
  output logic [15:0] last_width
);
  logic [15:0] width;
  logic prev;
  // Count closures and time each one; the counter only reads the contact
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pulse_count <= 16'h0000;
      last_width <= 16'h0000;
      width <= 16'h0000;
      prev <= 1'b0;
    end
    else
    begin
      prev <= relay_in;
      width <= relay_in ? width + 16'h0001 : 16'h0000;
      if (relay_in && !prev)
        pulse_count <= pulse_count + 16'h0001;
      if (!relay_in && prev)
        last_width <= width;
    end
  end
endmodule : mpil_totalizer

// File: test/mpil_top_tb.sv
// Self-checking bench for the meter pulse and indicator logic
`timescale 1ns/1ps
`include "mpil_defs.svh"
module mpil_top_tb;
  import mpil_pkg::*;
  localparam int PW = 20;
  localparam int RF = 40;
  logic mclk = 1'b0;
  logic resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, voltage_absent, energy_quantum;
  logic display_data, second_relay_req, energy_clear_jumper, power_on_indicator;
  logic diag_indicator, energy_relay, energy_pulse_indicator, second_relay;
  logic second_relay_indicator, address_valid, energy_clear, refresh_tick, irq, lvl;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic signed [15:0] total_power;
  logic [5:0] address_switch_bank, slave_address;
  logic [15:0] meas_a, meas_b, pulse_count, last_width;
  logic [11:0] analog_out0, analog_out1;
  int n_errors = 0;
  int samples_checked = 0;
  int tog, run, t1;
  // Rows: switch setting, expected address, expected valid flag
  logic [12:0] rows [6] = '{{6'h01, 6'h01, 1'b1}, {6'h05, 6'h05, 1'b1}, {6'h1E, 6'h1E, 1'b1},
    {6'h20, 6'h20, 1'b1}, {6'h3F, 6'h3F, 1'b1}, {6'h00, 6'h00, 1'b0}};

  // ********************
  // Design, far side and clock
  // ********************
  mpil_top #(.PULSE_CYC(PW), .REFRESH_CYC(RF), .FAST_CYC(4), .SLOW_CYC(8), .DBL_CYC(6)) i_dut (
    .mclk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .total_power, .voltage_absent, .energy_quantum, .display_data,
    .second_relay_req, .address_switch_bank, .energy_clear_jumper, .meas_a, .meas_b,
    .power_on_indicator, .diag_indicator, .energy_relay, .energy_pulse_indicator,
    .second_relay, .second_relay_indicator, .slave_address, .address_valid, .energy_clear,
    .analog_out0, .analog_out1, .refresh_tick, .irq);
  mpil_totalizer i_far (.mclk, .resetn, .relay_in(energy_relay), .pulse_count, .last_width);
  always #25 mclk = ~mclk;

  // ********************
  // Shared tasks
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // Classic single cycle; ack and read data are taken at the rising edge they stand at
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, 4'hF, dat};
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1)
    begin
      check(32'h0, 32'h1);
      end_of_test();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb

  // Jumper and switches are set while reset is held and sampled after its release
  task automatic do_reset(input logic jmp, input logic [5:0] sw);
    int k;
    @(posedge mclk);
    {resetn, energy_clear_jumper, address_switch_bank} <= {1'b0, jmp, sw};
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check({power_on_indicator, energy_relay, wb_ack_o, irq}, 4'h0);
    @(posedge mclk);
    resetn <= 1'b1;
    k = 0;
    repeat (6)
    begin
      @(negedge mclk);
      k += energy_clear;
    end
    check(k, jmp);
    check(power_on_indicator, 1'b1);
  endtask : do_reset

  // Counts diag toggles and its longest steady stretch, after a short settle
  task automatic watch(input int n, output int tg, output int mr, output logic lv);
    int r;
    tg = 0;
    mr = 0;
    r = 0;
    repeat (4) @(negedge mclk);
    lv = diag_indicator;
    repeat (n)
    begin
      @(negedge mclk);
      r = (diag_indicator === lv) ? r + 1 : 0;
      tg += (diag_indicator !== lv);
      mr = (r > mr) ? r : mr;
      lv = diag_indicator;
    end
  endtask : watch

  task automatic quantum(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      energy_quantum <= 1'b1;
      @(posedge mclk);
      energy_quantum <= 1'b0;
    end
    repeat (3 * PW) @(posedge mclk);
  endtask : quantum

  task automatic wait_tick(output int n);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (refresh_tick !== 1'b1 && n < 3 * RF);
    if (refresh_tick !== 1'b1)
    begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask : wait_tick

  task automatic settle();
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : settle

  // Indicators must track their relays on every settled cycle
  always @(negedge mclk)
  begin
    if (resetn)
    begin
      check(energy_pulse_indicator, energy_relay);
      check(second_relay_indicator, second_relay);
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    resetn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, total_power, voltage_absent,
      energy_quantum, display_data, second_relay_req, meas_a, meas_b, energy_clear_jumper,
      address_switch_bank} = '0;
    do_reset(1'b1, 6'h05);
    wb(1'b0, `MPIL_R_WEIGHT, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, `MPIL_R_SERIAL, 32'h0);
    check(rd, 32'h0008_2580);
    wb(1'b0, `MPIL_R_STATUS, 32'h0);
    check(rd[25:10], 16'h0005);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge mclk);
      address_switch_bank <= rows[i][12:7];
      settle();
      check(slave_address, rows[i][6:1]);
      check(address_valid, rows[i][0]);
    end
    do_reset(1'b1, 6'h05);
    do_reset(1'b0, 6'h05);
    // Diagnostic indicator patterns and their priority
    watch(40, tog, run, lvl);
    check(lvl, 1'b0);
    @(posedge mclk);
    total_power <= 16'hFFFB;
    watch(40, tog, run, lvl);
    check({tog[7:0], lvl}, 9'h001);
    @(posedge mclk);
    voltage_absent <= 1'b1;
    watch(120, tog, t1, lvl);
    check(tog > 0, 1'b1);
    wb(1'b1, `MPIL_R_CTRL, 32'h4);
    watch(120, tog, run, lvl);
    check(tog > 0 && run > t1, 1'b1);
    do_reset(1'b0, 6'h00);
    @(posedge mclk);
    {voltage_absent, total_power} <= '0;
    watch(120, tog, run, lvl);
    check(tog > 0 && run > t1, 1'b1);
    do_reset(1'b0, 6'h05);
    repeat (3 * RF)
    begin
      repeat (3) @(posedge mclk);
      total_power <= (total_power == 16'sh0005) ? 16'shFFFB : 16'sh0005;
    end
    wb(1'b0, `MPIL_R_IRQ, 32'h0);
    check(rd[1], 1'b1);
    // Relay pulses, weight, toggle mode and interrupt
    total_power <= 16'h0000;
    wb(1'b1, `MPIL_R_IRQ, 32'hF);
    wb(1'b1, `MPIL_R_MASK, 32'h1);
    check(irq, 1'b0);
    quantum(1);
    check(pulse_count, 16'h1);
    check(last_width >= PW && last_width <= PW + 2, 1'b1);
    check(irq, 1'b1);
    wb(1'b1, `MPIL_R_IRQ, 32'h1);
    settle();
    check(irq, 1'b0);
    wb(1'b1, `MPIL_R_MASK, 32'h0);
    quantum(1);
    check(irq, 1'b0);
    wb(1'b0, `MPIL_R_IRQ, 32'h0);
    check(rd[0], 1'b1);
    wb(1'b1, `MPIL_R_WEIGHT, 32'h3);
    quantum(2);
    check(pulse_count, 16'h2);
    quantum(1);
    check(pulse_count, 16'h3);
    wb(1'b1, `MPIL_R_WEIGHT, 32'h1);
    wb(1'b1, `MPIL_R_CTRL, 32'h1);
    quantum(1);
    check(energy_relay, 1'b1);
    quantum(1);
    check(energy_relay, 1'b0);
    // Second relay source and analog mapping
    wb(1'b1, `MPIL_R_CTRL, 32'h0);
    second_relay_req <= 1'b1;
    settle();
    check(second_relay, 1'b1);
    wb(1'b1, `MPIL_R_CTRL, 32'h2);
    settle();
    check(second_relay, 1'b0);
    @(posedge mclk);
    display_data <= 1'b1;
    settle();
    check(second_relay, 1'b1);
    wb(1'b1, `MPIL_R_AO0_SEL, 32'h1);
    meas_b <= 16'h03E8;
    wait_tick(t1);
    wait_tick(t1);
    check(t1, RF);
    wait_tick(t1);
    repeat (2) @(negedge mclk);
    check({analog_out0, analog_out1}, 24'hFFF000);
    // Seven quanta since the last jumper clear; only a shorted jumper zeroes them
    wb(1'b0, `MPIL_R_ENERGY, 32'h0);
    check(rd, 32'h7);
    do_reset(1'b0, 6'h05);
    wb(1'b0, `MPIL_R_ENERGY, 32'h0);
    check(rd, 32'h7);
    do_reset(1'b1, 6'h05);
    wb(1'b0, `MPIL_R_ENERGY, 32'h0);
    check(rd, 32'h0);
    end_of_test();
  end
endmodule : mpil_top_tb
